// >>> hdl/vrsed_pkg.sv
// Constants, field layout and decode helpers of the sensor edge detector.
// Assumes a 20 MHz system clock and signed converter samples in millivolts.
package vrsed_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned PEAK_SHORT_NS   = 10000;
    localparam int unsigned PEAK_LONG_NS    = 250000;
    localparam int unsigned FILT_0_NS       = 2000;
    localparam int unsigned FILT_1_NS       = 6000;
    localparam int unsigned FILT_2_NS       = 11000;
    localparam int unsigned FILT_3_NS       = 21000;
    localparam int unsigned SLOW_HALF_NS    = 500000;  // Speed split point
    localparam int unsigned PEAK_SHORT_CYC  =
        (PEAK_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PEAK_LONG_CYC   =
        (PEAK_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SLOW_HALF_CYC   =
        (SLOW_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // Widths and thresholds
    // ****************************************
    localparam int ADC_W  = 12;
    localparam int TIME_W = 13;
    localparam int FILT_W = 9;
    localparam int SPD_W  = 15;
    localparam logic [ADC_W-1:0] THR_0_MV = 12'h032;  // 50 mV
    localparam logic [ADC_W-1:0] THR_1_MV = 12'h096;  // 150 mV
    localparam logic [ADC_W-1:0] THR_2_MV = 12'h15e;  // 350 mV
    localparam logic [ADC_W-1:0] THR_3_MV = 12'h226;  // 550 mV

    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [7:0] REG_CONFIG_ZERO = 8'h00;
    localparam logic [7:0] REG_CONFIG_ONE  = 8'h04;
    localparam logic [7:0] REG_STATUS      = 8'h08;
    localparam int FILT_SEL_LSB = 0;
    localparam int THR_SEL_LSB  = 2;
    localparam int TIME_SEL_BIT = 4;
    localparam int MODE_LSB     = 0;
    localparam logic [1:0] FILT_SEL_RST = 2'h0;
    localparam logic [1:0] THR_SEL_RST  = 2'h0;
    localparam logic       TIME_SEL_RST = 1'b0;

    typedef enum logic [1:0] {
        VRSED_AUTO   = 2'h0,
        VRSED_MANUAL = 2'h1,
        VRSED_SEMI   = 2'h2,
        VRSED_HALL   = 2'h3
    } vrsed_mode_t;
    localparam vrsed_mode_t MODE_RST = VRSED_MANUAL;

    // Threshold in millivolts for a select code
    function automatic logic [ADC_W-1:0] vrsed_thr_mv(input logic [1:0] s);
        unique case (s)
            2'h0: vrsed_thr_mv = THR_0_MV;
            2'h1: vrsed_thr_mv = THR_1_MV;
            2'h2: vrsed_thr_mv = THR_2_MV;
            2'h3: vrsed_thr_mv = THR_3_MV;
        endcase
    endfunction : vrsed_thr_mv

    // Largest threshold not above half of the last peak
    function automatic logic [1:0] vrsed_thr_fit(input logic [ADC_W-1:0] p);
        logic [ADC_W:0] pk;
        pk = {1'b0, p};
        if (pk >= {vrsed_thr_mv(2'h3), 1'b0})      vrsed_thr_fit = 2'h3;
        else if (pk >= {vrsed_thr_mv(2'h2), 1'b0}) vrsed_thr_fit = 2'h2;
        else if (pk >= {vrsed_thr_mv(2'h1), 1'b0}) vrsed_thr_fit = 2'h1;
        else                                       vrsed_thr_fit = 2'h0;
    endfunction : vrsed_thr_fit

endpackage : vrsed_pkg

// >>> hdl/vrsed_out_filter.sv
// Output stability filter of the sensor edge detector.
// Assumes its input and select come from logic on the same clock.
`timescale 1ns/1ps
module vrsed_out_filter
    import vrsed_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              level_in,
    input  wire logic [FILT_W-1:0] hold_cycles,
    output logic                   level_out
);

    logic [FILT_W-1:0] diff_cnt_q;
    logic              level_q;

    // Count cycles that the input differs from the output
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            diff_cnt_q <= '0;
        end else if (level_in == level_q || diff_cnt_q == hold_cycles) begin
            diff_cnt_q <= '0;
        end else begin
            diff_cnt_q <= diff_cnt_q + 1'b1;
        end
    end

    // Pass the level once stable longer than the hold time
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            level_q <= 1'b0;
        end else if (level_in != level_q && diff_cnt_q == hold_cycles) begin
            level_q <= level_in;
        end
    end

    assign level_out = level_q;

endmodule : vrsed_out_filter

// >>> hdl/vrsed_peak_detect.sv
// Peak qualifier: slope reversal above threshold for a least time.
// Assumes converter samples arrive on the same clock with a valid strobe.
`timescale 1ns/1ps
module vrsed_peak_detect
    import vrsed_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    reset,
    input  wire logic signed [ADC_W-1:0] adc_sample,
    input  wire logic                    adc_valid,
    input  wire logic [ADC_W-1:0]        thr_mv,
    input  wire logic [TIME_W-1:0]       time_cycles,
    output logic                         peak_pulse,
    output logic [ADC_W-1:0]             magnitude
);

    logic signed [ADC_W-1:0] prev_q;
    logic [ADC_W-1:0]        mag_q;
    logic [ADC_W-1:0]        mag_d;
    logic                    above_q;
    logic [TIME_W-1:0]       above_cnt_q;
    logic                    dir_q;
    logic                    dir_ok_q;
    logic                    pulse_q;
    logic                    rising;
    logic                    falling;

    assign mag_d   = adc_sample[ADC_W-1] ? ADC_W'(~adc_sample + 1'b1)
                                         : adc_sample;
    assign rising  = adc_sample > prev_q;
    assign falling = adc_sample < prev_q;

    // Magnitude and above-threshold flag per sample
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mag_q   <= '0;
            above_q <= 1'b0;
            prev_q  <= '0;
        end else if (adc_valid) begin
            mag_q   <= mag_d;
            above_q <= mag_d > thr_mv;
            prev_q  <= adc_sample;
        end
    end

    // Continuous time above threshold, saturating
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            above_cnt_q <= '0;
        end else if (!above_q) begin
            above_cnt_q <= '0;
        end else if (above_cnt_q != '1) begin
            above_cnt_q <= above_cnt_q + 1'b1;
        end
    end

    // Slope sign tracking and qualified reversal
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dir_q    <= 1'b0;
            dir_ok_q <= 1'b0;
            pulse_q  <= 1'b0;
        end else begin
            pulse_q <= 1'b0;
            if (adc_valid && (rising || falling)) begin
                dir_q    <= rising;
                dir_ok_q <= 1'b1;
                pulse_q  <= dir_ok_q && (rising != dir_q) && above_q
                            && (above_cnt_q > time_cycles);
            end
        end
    end

    assign peak_pulse = pulse_q;
    assign magnitude  = mag_q;

endmodule : vrsed_peak_detect

// >>> hdl/vrsed_top.sv
// Digital detection path of a variable reluctance and Hall sensor input.
// Assumes analog comparators on pins, a converter on the same clock, and
// a classic Wishbone master for configuration and status.
`timescale 1ns/1ps
module vrsed_top
    import vrsed_pkg::*;
#(
    parameter int unsigned PEAK_LONG_CYCLES = PEAK_LONG_CYC,
    parameter int unsigned SLOW_HALF_CYCLES = SLOW_HALF_CYC
)
(
    input  wire logic                    clock,
    input  wire logic                    reset,
    // Wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    // Sensor front end
    input  wire logic signed [ADC_W-1:0] adc_sample,
    input  wire logic                    adc_valid,
    input  wire logic                    zero_cross_raw,
    input  wire logic                    hall_compare_raw,
    input  wire logic                    diag_short_bat_raw,
    input  wire logic                    diag_short_gnd_raw,
    input  wire logic                    diag_open_load_raw,
    output logic                         hall_reference_enable,
    output logic                         diagnosis_enable,
    output logic                         conditioned_sensor_output
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam int SYNC_N = 5;
    localparam logic [TIME_W-1:0] PEAK_LONG_T  = TIME_W'(PEAK_LONG_CYCLES);
    localparam logic [TIME_W-1:0] PEAK_SHORT_T = TIME_W'(PEAK_SHORT_CYC);
    localparam logic [SPD_W-1:0]  SLOW_HALF_T  = SPD_W'(SLOW_HALF_CYCLES);

    logic [SYNC_N-1:0] sync1_q;
    logic [SYNC_N-1:0] sync2_q;
    logic              zc_level;
    logic              hall_level;
    logic              diag_bat;
    logic              diag_gnd;
    logic              diag_open;

    logic              ack_q;
    logic [31:0]       rdata_q;
    logic              bus_req;
    logic              wr_zero;
    logic              wr_one;

    vrsed_mode_t       mode_q;
    logic [1:0]        filt_sel_q;
    logic [1:0]        thr_sel_q;
    logic              time_sel_q;

    logic              peak_pulse;
    logic [ADC_W-1:0]  magnitude;
    logic [ADC_W-1:0]  thr_mv;
    logic [TIME_W-1:0] time_cycles;
    logic [FILT_W-1:0] filt_cycles;

    logic              armed_q;
    logic              zc_prev_q;
    logic              result_q;
    logic              edge_take;
    logic              result_d;
    logic [ADC_W-1:0]  peak_max_q;
    logic [SPD_W-1:0]  half_cnt_q;
    logic              hall_q;
    logic              diag_on_q;
    logic              is_manual;
    logic              is_hall;
    logic              out_level;

    // ****************************************
    // Pin synchronisers
    // ****************************************

    // Two flip-flops for every asynchronous pin input
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {diag_open_load_raw, diag_short_gnd_raw,
                        diag_short_bat_raw, hall_compare_raw,
                        zero_cross_raw};
            sync2_q <= sync1_q;
        end
    end

    assign zc_level   = sync2_q[0];
    assign hall_level = sync2_q[1];
    assign diag_bat   = sync2_q[2];
    assign diag_gnd   = sync2_q[3];
    assign diag_open  = sync2_q[4];

    // ****************************************
    // Wishbone slave
    // ****************************************

    // A request is taken once per cycle pair; ack is a one-cycle pulse
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_zero = bus_req && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == REG_CONFIG_ZERO;
    assign wr_one  = bus_req && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == REG_CONFIG_ONE;

    // Acknowledge every request, mapped or not
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    // Read data captured with the request; unmapped reads give zero
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_q <= '0;
        end else if (bus_req && !wb_we_i) begin
            rdata_q <= '0;
            unique case (wb_adr_i)
                REG_CONFIG_ZERO: begin
                    rdata_q[FILT_SEL_LSB +: 2] <= filt_sel_q;
                    rdata_q[THR_SEL_LSB +: 2]  <= thr_sel_q;
                    rdata_q[TIME_SEL_BIT]      <= time_sel_q;
                end
                REG_CONFIG_ONE: begin
                    rdata_q[MODE_LSB +: 2] <= mode_q;
                end
                REG_STATUS: begin
                    rdata_q[0] <= conditioned_sensor_output;
                    rdata_q[1] <= armed_q;
                    rdata_q[2] <= result_q;
                    rdata_q[3] <= diag_bat && diag_on_q;
                    rdata_q[4] <= diag_gnd && diag_on_q;
                    rdata_q[5] <= diag_open && diag_on_q;
                    rdata_q[6] <= diag_on_q;
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // ****************************************
    // Configuration
    // ****************************************

    assign is_manual = mode_q == VRSED_MANUAL;
    assign is_hall   = mode_q == VRSED_HALL;

    // Detection mode field
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mode_q <= MODE_RST;
        end else if (wr_one) begin
            mode_q <= vrsed_mode_t'(wb_dat_i[MODE_LSB +: 2]);
        end
    end

    // Output filter select, host-owned in every mode
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            filt_sel_q <= FILT_SEL_RST;
        end else if (wr_zero) begin
            filt_sel_q <= wb_dat_i[FILT_SEL_LSB +: 2];
        end
    end

    // Effective threshold: host in manual, adapted in auto and semi
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            thr_sel_q <= THR_SEL_RST;
        end else if (wr_zero && is_manual) begin
            thr_sel_q <= wb_dat_i[THR_SEL_LSB +: 2];
        end else if (edge_take && (mode_q == VRSED_AUTO
                                   || mode_q == VRSED_SEMI)) begin
            thr_sel_q <= vrsed_thr_fit(peak_max_q);
        end
    end

    // Effective peak time: host in manual, speed-based in auto
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            time_sel_q <= TIME_SEL_RST;
        end else if (wr_zero && is_manual) begin
            time_sel_q <= wb_dat_i[TIME_SEL_BIT];
        end else if (edge_take && mode_q == VRSED_AUTO) begin
            time_sel_q <= half_cnt_q > SLOW_HALF_T;
        end
    end

    // Decode selections into compare values
    assign thr_mv      = vrsed_thr_mv(thr_sel_q);
    assign time_cycles = time_sel_q ? PEAK_LONG_T : PEAK_SHORT_T;

    // Filter hold time in cycles
    always_comb begin
        unique case (filt_sel_q)
            2'h0: filt_cycles = FILT_W'((FILT_0_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS);
            2'h1: filt_cycles = FILT_W'((FILT_1_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS);
            2'h2: filt_cycles = FILT_W'((FILT_2_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS);
            2'h3: filt_cycles = FILT_W'((FILT_3_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS);
        endcase
    end

    // ****************************************
    // Peak qualification
    // ****************************************

    vrsed_peak_detect u_peak (
        .clock       (clock),
        .reset       (reset),
        .adc_sample  (adc_sample),
        .adc_valid   (adc_valid),
        .thr_mv      (thr_mv),
        .time_cycles (time_cycles),
        .peak_pulse  (peak_pulse),
        .magnitude   (magnitude)
    );

    // ****************************************
    // Zero crossing and arming
    // ****************************************

    // Last synchronised comparator level, to see crossing edges
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            zc_prev_q <= 1'b0;
        end else begin
            zc_prev_q <= zc_level;
        end
    end

    // An armed crossing edge in VR modes, or a Hall level differing from result_q;
    // in VR modes an edge, not a level mismatch, so a missed first crossing cannot
    // pull the output onto the peaks
    assign edge_take = is_hall ? (hall_level != result_q)
                               : (armed_q && zc_level != zc_prev_q);
    assign result_d  = is_hall ? hall_level : zc_level;

    // Internal detection result holds between taken edges
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            result_q <= 1'b0;
        end else if (edge_take) begin
            result_q <= result_d;
        end
    end

    // Arm on a qualified peak; a peak in the edge cycle wins
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            armed_q <= 1'b0;
        end else if (peak_pulse && !is_hall) begin
            armed_q <= 1'b1;
        end else if (edge_take) begin
            armed_q <= 1'b0;
        end
    end

    // Largest magnitude of the current half wave
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            peak_max_q <= '0;
        end else if (edge_take) begin
            peak_max_q <= '0;
        end else if (magnitude > peak_max_q) begin
            peak_max_q <= magnitude;
        end
    end

    // Half period length as speed measure, saturating
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            half_cnt_q <= '0;
        end else if (edge_take) begin
            half_cnt_q <= '0;
        end else if (half_cnt_q != '1) begin
            half_cnt_q <= half_cnt_q + 1'b1;
        end
    end

    // ****************************************
    // Output filter and pin controls
    // ****************************************

    vrsed_out_filter u_filter (
        .clock       (clock),
        .reset       (reset),
        .level_in    (result_q),
        .hold_cycles (filt_cycles),
        .level_out   (out_level)
    );

    assign conditioned_sensor_output = out_level;

    // Reference on the second input and diagnosis enable
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hall_q    <= 1'b0;
            diag_on_q <= 1'b0;
        end else begin
            hall_q    <= is_hall;
            diag_on_q <= !is_hall;
        end
    end

    assign hall_reference_enable = hall_q;
    assign diagnosis_enable      = diag_on_q;

endmodule : vrsed_top

// >>> sim/vrsed_checker.sv
// Concurrent checks on the ports of the sensor edge detector top.
// Assumes it is bound to vrsed_top: one clock, asynchronous high reset.
`timescale 1ns/1ps
module vrsed_checker
    import vrsed_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        zero_cross_raw,
    input wire logic        hall_compare_raw,
    input wire logic        hall_reference_enable,
    input wire logic        diagnosis_enable,
    input wire logic        conditioned_sensor_output
);
    logic       src;
    logic       src_q;
    logic [9:0] stab_q;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Pin that the active mode listens to
    assign src = hall_reference_enable ? hall_compare_raw : zero_cross_raw;
    // Cycles since that pin last changed, saturating
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            src_q  <= 1'b0;
            stab_q <= '0;
        end else begin
            src_q  <= src;
            stab_q <= (src != src_q) ? '0 : stab_q + {9'h0, stab_q != '1};
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    a_out_settled: assert property (
        $changed(conditioned_sensor_output) |-> stab_q >= 10'h028)
        else $error("output changed before filter time");
    a_out_follows: assert property (
        $changed(conditioned_sensor_output) |-> conditioned_sensor_output == src)
        else $error("output moved away from input level");
    a_out_prompt: assert property (
        $changed(conditioned_sensor_output) |-> stab_q <= 10'h1c0)
        else $error("output moved long after input crossing");
    a_hall_diag_off: assert property (
        hall_reference_enable |-> !diagnosis_enable)
        else $error("diagnosis active in hall mode");
    a_out_reset_low: assert property (
        $fell(reset) |-> !conditioned_sensor_output)
        else $error("output not low after reset");
    a_mode_rst_manual: assert property (
        $fell(reset) |=> diagnosis_enable && !hall_reference_enable)
        else $error("reset mode is not manual");
    a_hall_status: assert property (
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == REG_STATUS
        && hall_reference_enable |-> wb_dat_o[6:3] == 4'h0)
        else $error("diagnosis bits set in hall mode");
endmodule : vrsed_checker

bind vrsed_top vrsed_checker chk_i (.*);

// >>> sim/vrsed_sensor_model.sv
// Behavioural reluctance sensor: converter samples and zero comparator.
// Assumes the bench sets amplitude and run only between frames.
`timescale 1ns/1ps
module vrsed_sensor_model
    import vrsed_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                run,
    input  wire logic [11:0]         amp,
    input  wire logic [11:0]         half,
    output logic signed [ADC_W-1:0] adc_sample,
    output logic                    adc_valid,
    output logic                    zero_cross_raw
);
    int q = 0;
    int x;
    int v;
    initial begin
        adc_sample = '0;
        adc_valid = 1'b0;
        zero_cross_raw = 1'b0;
    end
    // Triangle wave peaking mid half-wave, sampled every fourth cycle
    always @(posedge clock) begin
        q = run ? (q + 1) % (2 * int'(half)) : 0;
        x = q % int'(half);
        v = (2 * x < int'(half)) ? x : int'(half) - x;
        v = 2 * int'(amp) * v / int'(half);
        if (q >= int'(half)) v = -v;
        adc_valid <= run && (q % 4 == 0);
        adc_sample <= (run && q % 4 == 0) ? v[ADC_W-1:0] : ~adc_sample;
        zero_cross_raw <= run && v > 0;
    end
endmodule : vrsed_sensor_model

// >>> sim/vrsed_top_test.sv
// Self-checking bench of the sensor edge detector over Wishbone.
// Assumes the sensor model on converter and comparator pins.
`timescale 1ns/1ps
module vrsed_top_test;
    import vrsed_pkg::*;
    logic        clock, reset, cyc, stb, we, hall, run, ack, vr_out;
    logic        hall_ref, diag_en, valid, zc;
    logic [7:0]  adr;
    logic [31:0] wdat, rd, dat_o;
    logic [2:0]  diag;
    logic [11:0] amp;
    logic signed [ADC_W-1:0] sample;
    int err_total = 0;
    int n_checks = 0;
    int cyc_n = 0;
    int n;
    vrsed_top #(.PEAK_LONG_CYCLES(600), .SLOW_HALF_CYCLES(500)) uut (
        .clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .adc_sample(sample),
        .adc_valid(valid), .zero_cross_raw(zc), .hall_compare_raw(hall),
        .diag_short_bat_raw(diag[0]), .diag_short_gnd_raw(diag[1]),
        .diag_open_load_raw(diag[2]), .hall_reference_enable(hall_ref),
        .diagnosis_enable(diag_en), .conditioned_sensor_output(vr_out));
    vrsed_sensor_model sensor (.clock(clock), .run(run), .amp(amp),
        .half(12'h3e8), .adc_sample(sample), .adc_valid(valid),
        .zero_cross_raw(zc));
    task automatic end_of_test;
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One classic cycle, held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int k = 0;
        @(posedge clock);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clock);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = dat_o;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) err_total++;
    endtask : xfer
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    // Counts output changes over a number of cycles
    task automatic watch(input int cycles);
        logic prev = vr_out;
        n = 0;
        repeat (cycles) begin
            @(posedge clock);
            if (vr_out !== prev) n++;
            prev = vr_out;
        end
    endtask : watch
    // Configures with quiet inputs, then runs one signal frame
    task automatic sig(input logic [11:0] a, input logic [7:0] cfg);
        xfer(1'b1, REG_CONFIG_ZERO, {24'h0, cfg});
        amp <= a;
        run <= 1'b1;
        watch(5000);
        run <= 1'b0;
        repeat (600) @(posedge clock);
    endtask : sig
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Hang guard
    always @(posedge clock) begin
        cyc_n++;
        if (cyc_n == 60000) begin
            err_total++;
            end_of_test();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {reset, cyc, stb, we, hall, run, adr, wdat, diag, amp} = '0;
        reset = 1'b1;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        rdc(REG_CONFIG_ZERO, 32'h0);
        rdc(REG_CONFIG_ONE, 32'h1);
        rdc(REG_STATUS, 32'h40);
        xfer(1'b1, 8'h0c, 32'hff);
        rdc(8'h0c, 32'h0);
        xfer(1'b1, REG_CONFIG_ZERO, 32'h1f);
        rdc(REG_CONFIG_ZERO, 32'h1f);
        for (int m = 0; m < 4; m++) begin
            if (m == 1) continue;
            xfer(1'b1, REG_CONFIG_ONE, 32'h1);
            xfer(1'b1, REG_CONFIG_ZERO, 32'h0);
            xfer(1'b1, REG_CONFIG_ONE, 32'(m));
            xfer(1'b1, REG_CONFIG_ZERO, 32'h1f);
            rdc(REG_CONFIG_ZERO, 32'h03);
            rdc(REG_CONFIG_ONE, 32'(m));
        end
        xfer(1'b1, REG_CONFIG_ZERO, 32'h0);
        diag <= 3'h7;
        xfer(1'b0, REG_STATUS, 32'h0);
        chk(rd & 32'h78, 32'h0);
        chk({30'h0, hall_ref, diag_en}, 32'h2);
        hall <= 1'b1;
        repeat (20) @(posedge clock);
        hall <= 1'b0;
        watch(100);
        chk(32'(n), 32'h0);
        hall <= 1'b1;
        watch(100);
        chk({31'h0, vr_out}, 32'h1);
        hall <= 1'b0;
        watch(100);
        xfer(1'b1, REG_CONFIG_ONE, 32'h1);
        xfer(1'b0, REG_STATUS, 32'h0);
        chk(rd & 32'h78, 32'h78);
        diag <= 3'h0;
        sig(12'h064, 8'h00);
        chk(32'(n >= 3), 32'h1);
        sig(12'h028, 8'h00);
        chk(32'(n <= 1), 32'h1);
        sig(12'h064, 8'h04);
        chk(32'(n <= 1), 32'h1);
        sig(12'h12c, 8'h04);
        chk(32'(n >= 3), 32'h1);
        sig(12'h064, 8'h10);
        chk(32'(n <= 1), 32'h1);
        sig(12'h064, 8'h03);
        chk(32'(n >= 3), 32'h1);
        end_of_test();
    end
endmodule : vrsed_top_test
